// ---- hdl/bmr_conv_if.sv ----
`timescale 1ns/1ps
interface bmr_conv_if;
  logic long_sel;
  logic cycle_start;
  logic tick;
  logic unsync;

  modport pacer (
    input long_sel,
    input cycle_start,
    output tick,
    output unsync
  );

  modport ctrl (
    output long_sel,
    output cycle_start,
    input tick,
    input unsync
  );
endinterface : bmr_conv_if

// ---- hdl/bmr_pacer.sv ----
`timescale 1ns/1ps
module bmr_pacer #(
  parameter int SHORT_CYC = bmr_pkg::CONV_SHORT_CYC,
  parameter int LONG_CYC = bmr_pkg::CONV_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  bmr_conv_if.pacer cv
);

  localparam logic [bmr_pkg::CNT_W-1:0] SHORT_LAST = bmr_pkg::CNT_W'(SHORT_CYC - 1);
  localparam logic [bmr_pkg::CNT_W-1:0] LONG_LAST = bmr_pkg::CNT_W'(LONG_CYC - 1);

  typedef struct packed {
    logic [bmr_pkg::CNT_W-1:0] cnt;
    logic long_q;
    logic tick;
    logic unsync;
  } bmr_pace_t;

  bmr_pace_t s_q;
  bmr_pace_t s_d;
  logic [bmr_pkg::CNT_W-1:0] last;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    last = s_q.long_q ? LONG_LAST : SHORT_LAST;
    if (cv.cycle_start) begin
      // Bus cycle must end exactly on a conversion boundary; a bus start always starts a conversion
      s_d.long_q = cv.long_sel;
      s_d.unsync = (cv.long_sel != s_q.long_q) || (s_q.cnt != last);
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else if (cv.long_sel != s_q.long_q) begin
      // Period change restarts the phase; sync is lost until checked
      s_d.long_q = cv.long_sel;
      s_d.cnt = '0;
      s_d.unsync = 1'b1;
    end else if (s_q.cnt == last) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{cnt: '0, long_q: 1'b0, tick: 1'b0, unsync: 1'b1};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign cv.tick = s_q.tick;
  assign cv.unsync = s_q.unsync;

endmodule : bmr_pacer

// ---- hdl/bmr_pkg.sv ----
package bmr_pkg;

  // Clock and conversion timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CONV_SHORT_US = 50;
  localparam int CONV_LONG_US = 100;
  localparam int PS_PER_US = 1000000;
  localparam int CONV_SHORT_CYC = CONV_SHORT_US * PS_PER_US / CLK_PERIOD_PS;
  localparam int CONV_LONG_CYC = CONV_LONG_US * PS_PER_US / CLK_PERIOD_PS;
  localparam int CNT_W = 14;

  // Register byte offsets
  localparam logic [7:0] OFS_STATE = 8'h00;
  localparam logic [7:0] OFS_RANGE = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_SLOT0 = 8'h40;
  localparam logic [7:0] OFS_SLOT_LAST = 8'h64;

  // module_state_byte fields
  localparam int ST_INVALID = 0;
  localparam int ST_OPEN = 1;
  localparam int ST_UNSYNC = 2;

  // range_select fields
  localparam int RANGE_W = 3;
  localparam int RANGE_EXT_BIT = 2;
  localparam logic [7:0] RANGE_RST = 8'h00;

  // conversion_period_select codes
  localparam logic [7:0] PERIOD_50US = 8'h00;
  localparam logic [7:0] PERIOD_100US = 8'h01;
  localparam logic [7:0] PERIOD_RST = 8'h00;

  // Samples per bus cycle
  localparam int SLOTS = 10;
  localparam int SLOT_W = 16;
  localparam logic [3:0] SAMPLES_MIN = 4'h3;
  localparam logic [3:0] SAMPLES_MAX = 4'ha;
  localparam logic [3:0] COUNT_RST = 4'ha;

  // Interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_OPEN = 1;
  localparam int IRQ_UNSYNC = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Full-scale range in mV/V per range code
  localparam logic [8:0] MVV_16 = 9'h010;
  localparam logic [8:0] MVV_8 = 9'h008;
  localparam logic [8:0] MVV_4 = 9'h004;
  localparam logic [8:0] MVV_2 = 9'h002;
  localparam logic [8:0] MVV_256 = 9'h100;
  localparam logic [8:0] MVV_128 = 9'h080;
  localparam logic [8:0] MVV_64 = 9'h040;
  localparam logic [8:0] MVV_32 = 9'h020;

endpackage : bmr_pkg

// ---- hdl/bmr_top.sv ----
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module bmr_top #(
  parameter int CONV_SHORT_CYC = bmr_pkg::CONV_SHORT_CYC,
  parameter int CONV_LONG_CYC = bmr_pkg::CONV_LONG_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BUS_CYCLE,
  input wire logic ADC_DONE,
  input wire logic [15:0] ADC_DATA,
  input wire logic ADC_ERR,
  input wire logic ADC_OPEN,
  output logic CONV_START,
  output logic [2:0] GAIN_CODE,
  output logic RANGE_EXT,
  output logic [8:0] RANGE_MVV,
  output logic PERIOD_LONG,
  output logic IRQ
);

  typedef struct packed {
    logic [7:0] range;
    logic [7:0] period;
    logic [3:0] count;
    logic [bmr_pkg::IRQ_W-1:0] irq_stat;
    logic [bmr_pkg::IRQ_W-1:0] irq_mask;
    logic [bmr_pkg::SLOTS-1:0][bmr_pkg::SLOT_W-1:0] work;
    logic [3:0] widx;
    logic w_inv;
    logic w_open;
    logic [bmr_pkg::SLOTS-1:0][bmr_pkg::SLOT_W-1:0] slot;
    logic [3:0] slot_n;
    logic st_inv;
    logic st_open;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic conv_start;
    logic long_sel;
    logic [8:0] mvv;
  } bmr_state_t;

  // Power-up values; samples count as invalid until a cycle is delivered
  localparam bmr_state_t S_RST = '{
    range: bmr_pkg::RANGE_RST,
    period: bmr_pkg::PERIOD_RST,
    count: bmr_pkg::COUNT_RST,
    irq_stat: '0,
    irq_mask: bmr_pkg::IRQ_MASK_RST,
    work: '0,
    widx: '0,
    w_inv: 1'b0,
    w_open: 1'b0,
    slot: '0,
    slot_n: '0,
    st_inv: 1'b1,
    st_open: 1'b0,
    prdata: '0,
    pready: 1'b0,
    pslverr: 1'b0,
    irq: 1'b0,
    conv_start: 1'b0,
    long_sel: 1'b0,
    mvv: bmr_pkg::MVV_16
  };

  bmr_state_t s_q;
  bmr_state_t s_d;

  bmr_conv_if cv ();

  bmr_pacer #(
    .SHORT_CYC(CONV_SHORT_CYC),
    .LONG_CYC(CONV_LONG_CYC)
  ) u_pacer (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .cv(cv)
  );

  assign cv.long_sel = s_q.long_sel;
  assign cv.cycle_start = BUS_CYCLE;

  function automatic logic [8:0] range_mvv(input logic [2:0] code);
    logic [8:0] v;
    v = bmr_pkg::MVV_16;
    unique case (code)
      3'h0: v = bmr_pkg::MVV_16;
      3'h1: v = bmr_pkg::MVV_8;
      3'h2: v = bmr_pkg::MVV_4;
      3'h3: v = bmr_pkg::MVV_2;
      3'h4: v = bmr_pkg::MVV_256;
      3'h5: v = bmr_pkg::MVV_128;
      3'h6: v = bmr_pkg::MVV_64;
      3'h7: v = bmr_pkg::MVV_32;
    endcase
    return v;
  endfunction : range_mvv

  function automatic logic [3:0] clamp_count(input logic [31:0] w);
    logic [3:0] c;
    if (w < 32'(bmr_pkg::SAMPLES_MIN)) begin
      c = bmr_pkg::SAMPLES_MIN;
    end else if (w > 32'(bmr_pkg::SAMPLES_MAX)) begin
      c = bmr_pkg::SAMPLES_MAX;
    end else begin
      c = w[3:0];
    end
    return c;
  endfunction : clamp_count

  logic setup;
  logic access;
  logic addr_slot;
  logic [7:0] slot_ofs;
  logic [3:0] slot_sel;
  logic [7:0] state_byte;
  logic [bmr_pkg::IRQ_W-1:0] irq_set;
  logic [bmr_pkg::IRQ_W-1:0] irq_clr;
  logic open_now;

  always_comb begin
    s_d = s_q;
    setup = PSEL && !PENABLE;
    access = PSEL && PENABLE && s_q.pready;
    addr_slot = (PADDR >= bmr_pkg::OFS_SLOT0) && (PADDR <= bmr_pkg::OFS_SLOT_LAST) && (PADDR[1:0] == 2'h0);
    slot_ofs = PADDR - bmr_pkg::OFS_SLOT0;
    slot_sel = slot_ofs[5:2];
    irq_set = '0;
    irq_clr = '0;
    open_now = 1'b0;

    // Reserved bits 3..7 read zero
    state_byte = '0;
    state_byte[bmr_pkg::ST_INVALID] = s_q.st_inv;
    state_byte[bmr_pkg::ST_OPEN] = s_q.st_open;
    state_byte[bmr_pkg::ST_UNSYNC] = cv.unsync;

    // Converter samples of the running bus cycle
    if (BUS_CYCLE) begin
      // Hand over the finished cycle and start a fresh one
      s_d.slot = s_q.work;
      s_d.slot_n = s_q.widx;
      s_d.st_inv = s_q.w_inv || (s_q.widx < s_q.count);
      s_d.st_open = s_q.w_open;
      open_now = s_q.w_open;
      s_d.work = '0;
      s_d.widx = '0;
      s_d.w_inv = 1'b0;
      s_d.w_open = 1'b0;
      irq_set[bmr_pkg::IRQ_FRAME] = 1'b1;
      irq_set[bmr_pkg::IRQ_OPEN] = open_now;
      irq_set[bmr_pkg::IRQ_UNSYNC] = cv.unsync;
      if (ADC_DONE) begin
        s_d.work[0] = ADC_DATA;
        s_d.widx = 4'h1;
        s_d.w_inv = ADC_ERR;
        s_d.w_open = ADC_OPEN;
      end
    end else if (ADC_DONE && (s_q.widx < s_q.count)) begin
      // Only the configured number of samples is kept
      s_d.work[s_q.widx] = ADC_DATA;
      s_d.widx = s_q.widx + 1'b1;
      s_d.w_inv = s_q.w_inv || ADC_ERR;
      // Open flag is sticky within one bus cycle only
      s_d.w_open = s_q.w_open || ADC_OPEN;
    end

    // APB answer prepared during setup, given in first access cycle
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      if (addr_slot) begin
        if (slot_sel < s_q.slot_n) begin
          s_d.prdata = {16'h0000, s_q.slot[slot_sel]};
        end
      end else begin
        unique case (PADDR)
          bmr_pkg::OFS_STATE: s_d.prdata = {24'h000000, state_byte};
          bmr_pkg::OFS_RANGE: s_d.prdata = {24'h000000, s_q.range};
          bmr_pkg::OFS_PERIOD: s_d.prdata = {24'h000000, s_q.period};
          bmr_pkg::OFS_COUNT: s_d.prdata = {28'h0000000, s_q.count};
          bmr_pkg::OFS_IRQ_STAT: s_d.prdata = {29'h0000000, s_q.irq_stat};
          bmr_pkg::OFS_IRQ_MASK: s_d.prdata = {29'h0000000, s_q.irq_mask};
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end

    // Register writes and read side effects at access completion
    if (access && !s_q.pslverr) begin
      if (PWRITE) begin
        unique case (PADDR)
          bmr_pkg::OFS_RANGE: s_d.range = {5'h00, PWDATA[bmr_pkg::RANGE_W-1:0]};
          bmr_pkg::OFS_PERIOD: s_d.period = PWDATA[7:0];
          bmr_pkg::OFS_COUNT: s_d.count = clamp_count(PWDATA);
          bmr_pkg::OFS_IRQ_MASK: s_d.irq_mask = PWDATA[bmr_pkg::IRQ_W-1:0];
          default: s_d.range = s_q.range;
        endcase
      end else if (PADDR == bmr_pkg::OFS_IRQ_STAT) begin
        irq_clr = '1;
      end
    end

    // A new event in the clearing cycle is kept
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // Reserved period codes fall back to the 50 us period
    s_d.long_sel = (s_d.period == bmr_pkg::PERIOD_100US);
    s_d.mvv = range_mvv(s_d.range[bmr_pkg::RANGE_W-1:0]);
    s_d.conv_start = cv.tick;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_q <= S_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign CONV_START = s_q.conv_start;
  assign GAIN_CODE = s_q.range[bmr_pkg::RANGE_W-1:0];
  assign RANGE_EXT = s_q.range[bmr_pkg::RANGE_EXT_BIT];
  assign RANGE_MVV = s_q.mvv;
  assign PERIOD_LONG = s_q.long_sel;
  assign IRQ = s_q.irq;

endmodule : bmr_top

// ---- test/bmr_link_model.sv ----
`timescale 1ns/1ps
module bmr_link_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic [15:0] cycle_len,
  input wire logic bad,
  input wire logic open,
  output logic bus_cycle,
  output logic adc_done,
  output logic [15:0] adc_data,
  output logic adc_err,
  output logic adc_open
);
  logic [15:0] cnt_q, seq_q;
  logic [2:0] dly_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0;
      seq_q <= 16'ha000;
      dly_q <= 3'h0;
      bus_cycle <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 16'h0;
      adc_err <= 1'b0;
      adc_open <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= cycle_len - 16'h1) ? 16'h0 : cnt_q + 16'h1;
      bus_cycle <= cnt_q >= cycle_len - 16'h1;
      dly_q <= {dly_q[1:0], conv_start};
      adc_done <= dly_q[2];
      // Data and flags toggle outside the strobe
      adc_data <= dly_q[2] ? seq_q : ~adc_data;
      adc_err <= dly_q[2] ? bad : ~adc_err;
      adc_open <= dly_q[2] ? open : ~adc_open;
      seq_q <= seq_q + {15'h0, dly_q[2]};
    end
  end
endmodule : bmr_link_model

// ---- test/bmr_top_asserts.sv ----
`timescale 1ns/1ps
module bmr_top_asserts #(
  parameter int CONV_SHORT_CYC = bmr_pkg::CONV_SHORT_CYC,
  parameter int CONV_LONG_CYC = bmr_pkg::CONV_LONG_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BUS_CYCLE,
  input wire logic CONV_START,
  input wire logic [2:0] GAIN_CODE,
  input wire logic RANGE_EXT,
  input wire logic [8:0] RANGE_MVV,
  input wire logic PERIOD_LONG
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [15:0] gap_q;
  logic b1_q, b2_q, bc_q, arm_q, acc, pwr, mapped;
  assign acc = PSEL && PENABLE && PREADY;
  assign pwr = acc && PWRITE && PADDR == bmr_pkg::OFS_PERIOD;
  assign mapped = PADDR[1:0] == 2'h0 && (PADDR <= 8'h14 || (PADDR >= 8'h40 && PADDR <= 8'h64));
  // Gap between starts; restarts by bus cycle, period change or a clock-enable pause excused
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      gap_q <= 16'h0;
      b1_q <= 1'b0;
      b2_q <= 1'b0;
      bc_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      b1_q <= BUS_CYCLE;
      b2_q <= b1_q;
      gap_q <= CONV_START ? 16'h1 : gap_q + 16'h1;
      arm_q <= arm_q || CONV_START;
      bc_q <= BUS_CYCLE || pwr || !CE || (bc_q && !(CONV_START && b2_q));
    end
  end
  chk_ready_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("ready late");
  chk_ready_once: assert property (PREADY |=> !PREADY) else $error("ready held");
  chk_unmapped_err: assert property (acc |-> PSLVERR == !mapped) else $error("slverr wrong");
  chk_range_std: assert property (!GAIN_CODE[2] |-> RANGE_MVV == (9'h010 >> GAIN_CODE[1:0]) && !RANGE_EXT)
    else $error("std range wrong");
  chk_range_ext: assert property (GAIN_CODE[2] |-> RANGE_MVV == (9'h100 >> GAIN_CODE[1:0]) && RANGE_EXT)
    else $error("ext range wrong");
  chk_gain_write: assert property (acc && PWRITE && PADDR == bmr_pkg::OFS_RANGE |=>
    {29'h0, GAIN_CODE} == ($past(PWDATA) & 32'h7)) else $error("gain not taken");
  chk_period_sel: assert property (pwr |=> PERIOD_LONG == (($past(PWDATA) & 32'hff) == 32'h1))
    else $error("period select wrong");
  chk_start_bus: assert property (BUS_CYCLE |-> ##2 CONV_START) else $error("no start on cycle");
  chk_start_gap: assert property (CONV_START && arm_q && !bc_q |->
    gap_q == (PERIOD_LONG ? CONV_LONG_CYC : CONV_SHORT_CYC)) else $error("start gap wrong");
  cover property (acc && PSLVERR);
  cover property (CONV_START && PERIOD_LONG);
  cover property (acc && PWRITE && GAIN_CODE[2]);
endmodule : bmr_top_asserts
bind bmr_top bmr_top_asserts #(.CONV_SHORT_CYC(CONV_SHORT_CYC), .CONV_LONG_CYC(CONV_LONG_CYC)) bmr_top_asserts_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_CYCLE(BUS_CYCLE), .CONV_START(CONV_START),
  .GAIN_CODE(GAIN_CODE), .RANGE_EXT(RANGE_EXT), .RANGE_MVV(RANGE_MVV), .PERIOD_LONG(PERIOD_LONG));

// ---- test/test_bridge_multisample_readout.sv ----
`timescale 1ns/1ps
module test_bridge_multisample_readout;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, bus_cycle, adc_done, adc_err, adc_open;
  logic conv_start, range_ext, period_long, irq, se_v, bad, open, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [2:0] gain_code;
  logic [8:0] range_mvv;
  logic [15:0] adc_data, cycle_len;
  logic [15:0] cur_q[$], exp_q[$];
  int error_cnt = 0, check_count = 0, cyc = 0, starts = 0;
  always #4 sys_clk = ~sys_clk;
  bmr_top #(.CONV_SHORT_CYC(20), .CONV_LONG_CYC(40)) bmr_top_i (
    .SYS_CLK(sys_clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUS_CYCLE(bus_cycle), .ADC_DONE(adc_done), .ADC_DATA(adc_data), .ADC_ERR(adc_err),
    .ADC_OPEN(adc_open), .CONV_START(conv_start), .GAIN_CODE(gain_code), .RANGE_EXT(range_ext),
    .RANGE_MVV(range_mvv), .PERIOD_LONG(period_long), .IRQ(irq));
  bmr_link_model bmr_link_model_i (.clk(sys_clk), .rst(rst), .conv_start(conv_start), .cycle_len(cycle_len),
    .bad(bad), .open(open), .bus_cycle(bus_cycle), .adc_done(adc_done), .adc_data(adc_data),
    .adc_err(adc_err), .adc_open(adc_open));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_v = prdata;
    se_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_v);
  endtask : rdc
  task automatic wait_bc(input int n);
    repeat (n) @(posedge sys_clk iff bus_cycle);
    repeat (3) @(posedge sys_clk);
  endtask : wait_bc
  task automatic chk_slots(input int n);
    for (int k = 0; k < 10; k++) begin
      rdc("slot", bmr_pkg::OFS_SLOT0 + 8'(4 * k), (k < n && k < exp_q.size()) ? {16'h0, exp_q[k]} : 32'h0);
    end
  endtask : chk_slots
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Samples of one bus cycle become the expected slots at its end
  always @(posedge sys_clk) begin
    if (bus_cycle) begin
      exp_q = cur_q;
      cur_q = {};
    end
    if (adc_done) cur_q.push_back(adc_data);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, bad, open} = 5'h0;
    ce = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    cycle_len = 16'h64;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rdc("state", bmr_pkg::OFS_STATE, 32'h5);
    rdc("period", bmr_pkg::OFS_PERIOD, 32'h0);
    rdc("count", bmr_pkg::OFS_COUNT, 32'ha);
    rdc("range", bmr_pkg::OFS_RANGE, 32'h0);
    chk("mvv", 32'h10, {23'h0, range_mvv});
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, bmr_pkg::OFS_RANGE, 32'hf8 | 32'(k));
      rdc("range", bmr_pkg::OFS_RANGE, 32'(k));
      chk("gain", 32'(k), {29'h0, gain_code});
      chk("mvv", {23'h0, (k[2] ? 9'h100 : 9'h010) >> k[1:0]}, {23'h0, range_mvv});
      chk("ext", 32'(k[2]), {31'h0, range_ext});
    end
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se_v});
    apb(1'b1, bmr_pkg::OFS_COUNT, 32'h2);
    rdc("count", bmr_pkg::OFS_COUNT, 32'h3);
    apb(1'b1, bmr_pkg::OFS_COUNT, 32'hf);
    rdc("count", bmr_pkg::OFS_COUNT, 32'ha);
    apb(1'b1, bmr_pkg::OFS_COUNT, 32'h5);
    $display("test config done");
    wait_bc(3);
    rdc("state", bmr_pkg::OFS_STATE, 32'h0);
    chk_slots(5);
    wait_bc(1);
    apb(1'b1, bmr_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, bmr_pkg::OFS_IRQ_STAT, 32'h0);
    chk("frame", 32'h1, rd_v & 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, bmr_pkg::OFS_IRQ_MASK, 32'h0);
    $display("test sampling done");
    open <= 1'b1;
    wait_bc(2);
    rdc("state", bmr_pkg::OFS_STATE, 32'h2);
    apb(1'b0, bmr_pkg::OFS_IRQ_STAT, 32'h0);
    chk("open_irq", 32'h2, rd_v & 32'h2);
    open <= 1'b0;
    wait_bc(2);
    rdc("state", bmr_pkg::OFS_STATE, 32'h0);
    bad <= 1'b1;
    wait_bc(2);
    rdc("state", bmr_pkg::OFS_STATE, 32'h1);
    bad <= 1'b0;
    cycle_len <= 16'h6e;
    wait_bc(3);
    rdc("state", bmr_pkg::OFS_STATE, 32'h4);
    apb(1'b0, bmr_pkg::OFS_IRQ_STAT, 32'h0);
    chk("sync_irq", 32'h4, rd_v & 32'h4);
    cycle_len <= 16'h64;
    wait_bc(3);
    rdc("state", bmr_pkg::OFS_STATE, 32'h0);
    $display("test status done");
    apb(1'b1, bmr_pkg::OFS_PERIOD, 32'h1);
    apb(1'b1, bmr_pkg::OFS_COUNT, 32'h3);
    cycle_len <= 16'h78;
    wait_bc(3);
    chk("long", 32'h1, {31'h0, period_long});
    rdc("state", bmr_pkg::OFS_STATE, 32'h0);
    chk_slots(3);
    $display("test long period done");
    // Freeze right after a start pulse, well clear of the next bus cycle
    wait_bc(1);
    @(posedge sys_clk iff conv_start);
    ce <= 1'b0;
    repeat (60) @(posedge sys_clk) if (conv_start !== 1'b0) starts++;
    chk("frozen", 32'h0, 32'(starts));
    ce <= 1'b1;
    $display("test clock enable done");
    end_of_test();
  end
endmodule : test_bridge_multisample_readout
